/* rtl/exp_bus_consts.svh */
// Timing counts, field positions and park levels for the expansion bus
`ifndef EXP_BUS_CONSTS_SVH
`define EXP_BUS_CONSTS_SVH
`define EXP_CLK_FIELD_LSB      3
`define EXP_CLK_FIELD_MSB      5
`define EXP_SRC_INTERNAL       1'b0
`define EXP_SRC_EXT_PIN        1'b1
`define EXP_STROBE_CYCLES      2
`define EXP_DATA_CYCLES        4
`define EXP_PARK_LEVEL         8'h00
`define EXP_UPPER_LSB          16
`define EXP_UPPER_MSB          19
`endif

/* rtl/exp_bus_pkg.sv */
// Types shared by the expansion bus modules
package exp_bus_pkg;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_STROBE,
        PH_DATA
    } phase_type;
endpackage : exp_bus_pkg

/* rtl/exp_tick_if.sv */
// Carrier for the selected bus tick between the clock selector and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface exp_tick_if;
    logic tick;
    modport source (output tick);
    modport sink   (input tick);
endinterface : exp_tick_if
`default_nettype wire

/* rtl/exp_clock_select.sv */
// Expansion bus tick generator: selects source and divides by factor plus one
`timescale 1ns/1ps
`default_nettype none
`include "exp_bus_consts.svh"
module exp_clock_select (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       exp_bus_ext_clock,
    input  wire logic       exp_clock_source_sel,
    input  wire logic [1:0] exp_clock_factor,
    exp_tick_if.source      tick_out
);
    logic       ext_meta_reg;
    logic       ext_sync_reg;
    logic       ext_prev_reg;
    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic       base_tick;
    logic       tick_reg;
    logic       tick_next;

    assign base_tick = (exp_clock_source_sel == `EXP_SRC_EXT_PIN) ? (ext_sync_reg & ~ext_prev_reg) : 1'b1;

    always_comb begin
        div_next  = div_reg;
        tick_next = 1'b0;
        if (base_tick) begin
            if (div_reg >= {1'b0, exp_clock_factor}) begin
                div_next  = 3'h0;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
            div_reg      <= 3'h0;
            tick_reg     <= 1'b0;
        end else begin
            ext_meta_reg <= exp_bus_ext_clock;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
            div_reg      <= div_next;
            tick_reg     <= tick_next;
        end
    end

    assign tick_out.tick = tick_reg;

    // tick never back to back when divided
    property p_div_spacing;
        @(posedge clk_sys) disable iff (reset)
        (tick_reg && exp_clock_factor != 2'h0 ##1 $stable(exp_clock_factor)) |-> !tick_reg;
    endproperty
    a_div_spacing: assert property (p_div_spacing) else $error("tick repeated under divide");
endmodule : exp_clock_select
`default_nettype wire

/* rtl/boot_rom_expansion_bus.sv */
// Expansion bus master for an external boot EPROM or flash
// Notes on behaviour
// - Upper address bits 19:16 valid at strobe rise
// - Low address byte follows on shared lane
// - Middle lane carries address 15:8 while selected
// - Low data lane carries data both ways
// - Shared address lane parked when idle
// - Middle lane parked when idle
// - Low data lane forced constant when idle
// - Chip select low only in data phase
// - One strobe rising edge per access
// - Strobe low on reads, high on writes
// - Write enable pulses for flash writes
// - Clock source and factor select bus clock
// - External clock drives this bus and sram_tick
// - Same clock times SRAM and boot cycles
`timescale 1ns/1ps
`default_nettype none
`include "exp_bus_consts.svh"
module boot_rom_expansion_bus
    import exp_bus_pkg::*;
#(
    parameter int STROBE_CYCLES = `EXP_STROBE_CYCLES,
    parameter int DATA_CYCLES   = `EXP_DATA_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        exp_bus_ext_clock,
    input  wire logic [2:0]  exp_bus_clock_config_reg,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [19:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    output logic             sram_tick,
    output logic [7:0]       upper_then_low_addr_lane,
    output logic [7:0]       mid_addr_data_lane_out,
    output logic             mid_addr_data_lane_oe,
    input  wire logic [7:0]  low_data_lane_in,
    output logic [7:0]       low_data_lane_out,
    output logic             low_data_lane_oe,
    output logic             boot_device_select_n,
    output logic             addr_strobe_output_enable_n,
    output logic             flash_write_enable_n
);
    initial begin
        if (STROBE_CYCLES < 2 || STROBE_CYCLES > 15 || DATA_CYCLES < 3 || DATA_CYCLES > 15)
            $error("boot_rom_expansion_bus: unsupported phase lengths");
    end

    localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYCLES - 1);
    localparam logic [3:0] DATA_LAST   = 4'(DATA_CYCLES - 1);

    // ************************************************************
    // Bus clock selection
    // ************************************************************
    exp_tick_if tick_bus ();

    // external clock feeds only this selector
    exp_clock_select u_clock_select (
        .clk_sys              (clk_sys),
        .reset                (reset),
        .exp_bus_ext_clock    (exp_bus_ext_clock),
        .exp_clock_source_sel (exp_bus_clock_config_reg[`EXP_CLK_FIELD_MSB - `EXP_CLK_FIELD_LSB]),
        .exp_clock_factor     (exp_bus_clock_config_reg[1:0]),
        .tick_out             (tick_bus.source)
    );

    logic tick;
    assign tick = tick_bus.tick;
    assign sram_tick = tick;

    // ************************************************************
    // Data lane input synchroniser
    // ************************************************************
    logic [7:0] din_meta_reg;
    logic [7:0] din_sync_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            din_meta_reg <= `EXP_PARK_LEVEL;
            din_sync_reg <= `EXP_PARK_LEVEL;
        end else begin
            din_meta_reg <= low_data_lane_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // ************************************************************
    // Access sequencer
    // ************************************************************
    phase_type   phase_reg;
    phase_type   phase_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic        write_reg;
    logic        write_next;
    logic [19:0] addr_reg;
    logic [19:0] addr_next;
    logic [7:0]  wdata_reg;
    logic [7:0]  wdata_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        rsp_reg;
    logic        rsp_next;

    assign req_ready = (phase_reg == PH_IDLE);

    always_comb begin
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        write_next = write_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        rsp_next   = 1'b0;
        unique case (phase_reg)
            PH_IDLE: begin
                if (req_valid) begin
                    phase_next = PH_STROBE;
                    cnt_next   = 4'h0;
                    write_next = req_write;
                    addr_next  = req_addr;
                    wdata_next = req_wdata;
                end
            end
            PH_STROBE: begin
                if (tick) begin
                    if (cnt_reg == STROBE_LAST) begin
                        phase_next = PH_DATA;
                        cnt_next   = 4'h0;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            PH_DATA: begin
                if (tick) begin
                    if (cnt_reg == DATA_LAST) begin
                        phase_next = PH_IDLE;
                        cnt_next   = 4'h0;
                        rsp_next   = 1'b1;
                        if (!write_reg) begin
                            rdata_next = din_sync_reg;
                        end
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phase_reg <= PH_IDLE;
            cnt_reg   <= 4'h0;
            write_reg <= 1'b0;
            addr_reg  <= 20'h00000;
            wdata_reg <= `EXP_PARK_LEVEL;
            rdata_reg <= `EXP_PARK_LEVEL;
            rsp_reg   <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            cnt_reg   <= cnt_next;
            write_reg <= write_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            rsp_reg   <= rsp_next;
        end
    end

    assign rsp_valid = rsp_reg;
    assign rsp_rdata = rdata_reg;

    // ************************************************************
    // Pin drivers, registered
    // ************************************************************
    logic [7:0] ua_next;
    logic [7:0] ua_reg;
    logic [7:0] mid_next;
    logic [7:0] mid_reg;
    logic [7:0] dout_next;
    logic [7:0] dout_reg;
    logic       doe_next;
    logic       doe_reg;
    logic       cs_n_next;
    logic       cs_n_reg;
    logic       oe_n_next;
    logic       oe_n_reg;
    logic       we_n_next;
    logic       we_n_reg;

    always_comb begin
        ua_next   = `EXP_PARK_LEVEL;
        mid_next  = `EXP_PARK_LEVEL;
        dout_next = `EXP_PARK_LEVEL;
        doe_next  = 1'b1;
        cs_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        unique case (phase_next)
            PH_IDLE: begin
            end
            PH_STROBE: begin
                ua_next   = {4'h0, addr_next[`EXP_UPPER_MSB:`EXP_UPPER_LSB]};
                // low, then rises on last strobe tick while upper byte stands
                oe_n_next = (cnt_next == STROBE_LAST);
            end
            PH_DATA: begin
                ua_next   = addr_next[7:0];
                mid_next  = addr_next[15:8];
                cs_n_next = 1'b0;
                // drive on writes, release on reads
                dout_next = write_next ? wdata_next : `EXP_PARK_LEVEL;
                doe_next  = write_next;
                oe_n_next = write_next;
                // write pulse inside the select window
                we_n_next = !(write_next && cnt_next != 4'h0 && cnt_next != DATA_LAST);
            end
        endcase
    end

    // Strobe ending one cycle early would violate latch setup, hence the gap
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ua_reg   <= `EXP_PARK_LEVEL;
            mid_reg  <= `EXP_PARK_LEVEL;
            dout_reg <= `EXP_PARK_LEVEL;
            doe_reg  <= 1'b1;
            cs_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
        end else begin
            ua_reg   <= ua_next;
            mid_reg  <= mid_next;
            dout_reg <= dout_next;
            doe_reg  <= doe_next;
            cs_n_reg <= cs_n_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
        end
    end

    assign upper_then_low_addr_lane    = ua_reg;
    assign mid_addr_data_lane_out      = mid_reg;
    assign mid_addr_data_lane_oe       = 1'b1;
    assign low_data_lane_out           = dout_reg;
    assign low_data_lane_oe            = doe_reg;
    assign boot_device_select_n        = cs_n_reg;
    assign addr_strobe_output_enable_n = oe_n_reg;
    assign flash_write_enable_n        = we_n_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    logic [19:0] addr_q;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            addr_q <= 20'h00000;
        end else begin
            addr_q <= addr_reg;
        end
    end

    property p_upper_at_rise;
        @(posedge clk_sys) disable iff (reset)
        $rose(addr_strobe_output_enable_n) && $past(boot_device_select_n) |-> upper_then_low_addr_lane == {4'h0, addr_q[19:16]};
    endproperty
    a_upper_at_rise: assert property (p_upper_at_rise) else $error("upper address not valid at strobe rise");

    property p_low_in_data;
        @(posedge clk_sys) disable iff (reset)
        !boot_device_select_n |-> upper_then_low_addr_lane == addr_q[7:0];
    endproperty
    a_low_in_data: assert property (p_low_in_data) else $error("low address missing in data phase");

    property p_mid_in_data;
        @(posedge clk_sys) disable iff (reset)
        !boot_device_select_n |-> mid_addr_data_lane_out == addr_q[15:8];
    endproperty
    a_mid_in_data: assert property (p_mid_in_data) else $error("middle address missing while selected");

    property p_idle_parked;
        @(posedge clk_sys) disable iff (reset)
        $past(phase_reg == PH_IDLE) && phase_reg == PH_IDLE |->
            upper_then_low_addr_lane == 8'h00 && mid_addr_data_lane_out == 8'h00 && low_data_lane_out == 8'h00
            && low_data_lane_oe;
    endproperty
    a_idle_parked: assert property (p_idle_parked) else $error("lanes not parked while idle");

    property p_cs_only_data;
        @(posedge clk_sys) disable iff (reset)
        !boot_device_select_n |-> phase_reg == PH_DATA;
    endproperty
    a_cs_only_data: assert property (p_cs_only_data) else $error("select outside data phase");

    property p_read_oe;
        @(posedge clk_sys) disable iff (reset)
        !boot_device_select_n && !write_reg |-> !addr_strobe_output_enable_n && !low_data_lane_oe;
    endproperty
    a_read_oe: assert property (p_read_oe) else $error("read without output enable");

    property p_write_no_oe;
        @(posedge clk_sys) disable iff (reset)
        !boot_device_select_n && write_reg |-> addr_strobe_output_enable_n && low_data_lane_oe
            && low_data_lane_out == wdata_reg;
    endproperty
    a_write_no_oe: assert property (p_write_no_oe) else $error("write drove output enable");

    property p_we_inside_cs;
        @(posedge clk_sys) disable iff (reset)
        !flash_write_enable_n |-> !boot_device_select_n && write_reg;
    endproperty
    a_we_inside_cs: assert property (p_we_inside_cs) else $error("write enable outside flash write");

    property p_strobe_then_data;
        @(posedge clk_sys) disable iff (reset)
        $rose(phase_reg == PH_STROBE) |-> !addr_strobe_output_enable_n && boot_device_select_n;
    endproperty
    a_strobe_then_data: assert property (p_strobe_then_data) else $error("strobe phase malformed");
endmodule : boot_rom_expansion_bus
`default_nettype wire

/* tb/boot_dev_model.sv */
// Behavioural boot flash with its external upper address register
`timescale 1ns/1ps
`default_nettype none
module boot_dev_model (
    input  wire logic [7:0] upper_then_low_addr_lane,
    input  wire logic [7:0] mid_addr_data_lane_out,
    input  wire logic [7:0] low_data_lane,
    input  wire logic       boot_device_select_n,
    input  wire logic       addr_strobe_output_enable_n,
    input  wire logic       flash_write_enable_n,
    output logic      [7:0] data_out
);
    logic [7:0]  mem [int];
    logic [3:0]  upper_reg = 4'h0;
    logic [7:0]  rd_val;
    logic [7:0]  last_q = 8'h00;
    logic [19:0] addr;
    logic        drv;
    // ****
    // Storage
    // ****
    // edge register
    always @(posedge addr_strobe_output_enable_n) upper_reg = upper_then_low_addr_lane[3:0];
    assign addr = {upper_reg, mid_addr_data_lane_out, upper_then_low_addr_lane};
    assign drv = !boot_device_select_n && !addr_strobe_output_enable_n && flash_write_enable_n;
    always @(posedge flash_write_enable_n) if (!boot_device_select_n) mem[addr] = low_data_lane;
    always @* rd_val = mem.exists(addr) ? mem[addr] : (addr[7:0] ^ addr[15:8] ^ {4'h0, addr[19:16]} ^ 8'h5a);
    always @* if (drv) last_q = rd_val;
    // No pull on this lane, so a released lane must not echo old data
    assign data_out = drv ? rd_val : ~last_q;
endmodule : boot_dev_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the boot device expansion bus master
`timescale 1ns/1ps
`default_nettype none
`include "exp_bus_consts.svh"
module tb_top
    import exp_bus_pkg::*;
;
    logic clk_sys = 0, reset = 1, exp_bus_ext_clock = 0, ext_run = 1;
    logic [2:0] cfg_reg = 3'h0;
    logic req_valid = 0, req_write = 0, req_ready, rsp_valid, sram_tick;
    logic [19:0] req_addr = 20'h00000;
    logic [7:0] req_wdata = 8'h00, rsp_rdata, ua_lane, mid_lane, low_out, low_in, model_out;
    logic mid_oe, low_oe, cs_n, oe_n, we_n;
    int bad_count = 0, checks = 0, stall_ticks = 0;
    logic [31:0] rng = 32'h437786cf;
    logic [7:0] ref_mem [int];
    always #5 clk_sys = ~clk_sys;
    // Far-side clock, unrelated in phase
    always #17 if (ext_run) exp_bus_ext_clock = ~exp_bus_ext_clock;
    assign low_in = low_oe ? low_out : model_out;
    boot_rom_expansion_bus dut (.clk_sys(clk_sys), .reset(reset), .exp_bus_ext_clock(exp_bus_ext_clock),
        .exp_bus_clock_config_reg(cfg_reg), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .sram_tick(sram_tick), .upper_then_low_addr_lane(ua_lane),
        .mid_addr_data_lane_out(mid_lane), .mid_addr_data_lane_oe(mid_oe), .low_data_lane_in(low_in),
        .low_data_lane_out(low_out), .low_data_lane_oe(low_oe), .boot_device_select_n(cs_n),
        .addr_strobe_output_enable_n(oe_n), .flash_write_enable_n(we_n));
    boot_dev_model partner (.upper_then_low_addr_lane(ua_lane), .mid_addr_data_lane_out(mid_lane),
        .low_data_lane(low_in), .boot_device_select_n(cs_n), .addr_strobe_output_enable_n(oe_n),
        .flash_write_enable_n(we_n), .data_out(model_out));
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs
    task automatic fail_msg(input string m);
        bad_count++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail_msg
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) fail_msg($sformatf("byte %h want %h", got, exp));
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) fail_msg($sformatf("bit %b want %b", got, exp));
    endtask : cmp1
    task automatic cmp_cnt(input int got, input int exp);
        checks++;
        if (got != exp) fail_msg($sformatf("count %0d want %0d", got, exp));
    endtask : cmp_cnt
    task automatic idle_check(input int n);
        int gap = 0;
        repeat (n) begin
            @(negedge clk_sys);
            cmp8(ua_lane, `EXP_PARK_LEVEL);
            cmp8(mid_lane, `EXP_PARK_LEVEL);
            cmp1(mid_oe, 1'b1);
            cmp8(low_out, `EXP_PARK_LEVEL);
            cmp1(low_oe, 1'b1);
            cmp1(cs_n, 1'b1);
            cmp1(req_ready, 1'b1);
            if (sram_tick === 1'b1) begin
                if (gap > 0 && !cfg_reg[2]) cmp_cnt(gap, cfg_reg[1:0] + 1);
                gap = 1;
            end else if (gap > 0) gap++;
        end
    endtask : idle_check
    task automatic do_access(input logic wr, input logic [19:0] a, input logic [7:0] d);
        int rises = 0, we_lo = 0, ticks = 0, cyc = 0;
        logic prev_oe = 1'b1;
        logic prev_cs = 1'b1;
        logic [7:0] exp_rd;
        exp_rd = ref_mem.exists(a) ? ref_mem[a] : (a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]} ^ 8'h5a);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do begin @(negedge clk_sys); cyc++; end while (req_ready !== 1'b1 && cyc < 100);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        while (cyc < 2000) begin
            @(negedge clk_sys);
            cyc++;
            if (sram_tick === 1'b1) ticks++;
            // Closing rise of a read comes with select release, not a strobe
            if (prev_oe === 1'b0 && oe_n === 1'b1 && prev_cs === 1'b1) begin
                rises++;
                cmp8(ua_lane, {4'h0, a[19:16]});
            end
            if (we_n === 1'b0) begin
                we_lo++;
                cmp1(cs_n, 1'b0);
            end
            if (cs_n === 1'b0) begin
                cmp_cnt(rises, 1);
                cmp8(ua_lane, a[7:0]);
                cmp8(mid_lane, a[15:8]);
                cmp1(oe_n, wr);
                cmp1(low_oe, wr);
                if (wr) cmp8(low_out, d);
            end
            prev_oe = oe_n;
            prev_cs = cs_n;
            if (rsp_valid === 1'b1) break;
        end
        cmp1(rsp_valid, 1'b1);
        cmp_cnt(rises, 1);
        cmp_cnt(we_lo > 0, wr);
        cmp_cnt(ticks >= `EXP_STROBE_CYCLES + `EXP_DATA_CYCLES - 1
                && ticks <= `EXP_STROBE_CYCLES + `EXP_DATA_CYCLES + 1, 1);
        if (wr) ref_mem[a] = d;
        else cmp8(rsp_rdata, exp_rd);
    endtask : do_access
    task automatic close_out;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    // ****
    // Sequence
    // ****
    initial begin
        #300000;
        fail_msg("watchdog expired");
        close_out;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        idle_check(6);
        do_access(1'b0, 20'h00000, 8'h00);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_sys);
            cfg_reg <= c[2:0];
            repeat (8) @(posedge clk_sys);
            idle_check(12);
            do_access(1'b1, 20'hfffff - c, 8'ha5 ^ c[7:0]);
            for (int k = 0; k < 3; k++) begin
                rng = xs(rng);
                do_access(rng[8], rng[27:8], rng[7:0]);
            end
            do_access(1'b0, 20'hfffff - c, 8'h00);
            idle_check(4);
        end
        // Stopped pin clock must freeze the bus when selected
        @(posedge clk_sys);
        cfg_reg <= 3'b100;
        ext_run = 1'b0;
        repeat (10) @(posedge clk_sys);
        fork
            do_access(1'b0, 20'h3c0de, 8'h00);
            begin
                repeat (40) @(negedge clk_sys) if (sram_tick === 1'b1) stall_ticks++;
                cmp_cnt(stall_ticks, 0);
                ext_run = 1'b1;
            end
        join
        close_out;
    end
endmodule : tb_top
`default_nettype wire
